// ===== src/fnd_pkg.sv
// constants and helpers for the fractional-n divider control block
package fnd_pkg;
   // ---------------------------------------------------------------
   // register bus geometry
   // ---------------------------------------------------------------
   localparam int ADDR_W = 5;
   localparam int DATA_W = 24;
   localparam int INT_W = 19;
   localparam int FRAC_W = 24;
   localparam int DIV_W = 20;
   // ---------------------------------------------------------------
   // register offsets
   // ---------------------------------------------------------------
   localparam logic [ADDR_W-1:0] OFF_REF_DIV = 5'h02;
   localparam logic [ADDR_W-1:0] OFF_INT = 5'h03;
   localparam logic [ADDR_W-1:0] OFF_FRAC = 5'h04;
   localparam logic [ADDR_W-1:0] OFF_VDIV = 5'h05;
   localparam logic [ADDR_W-1:0] OFF_MODE = 5'h06;
   localparam logic [ADDR_W-1:0] OFF_PRESC = 5'h08;
   localparam logic [ADDR_W-1:0] OFF_EXACT = 5'h0C;
   localparam logic [ADDR_W-1:0] OFF_STATUS = 5'h10;
   // ---------------------------------------------------------------
   // field positions
   // ---------------------------------------------------------------
   localparam int VDIV_LSB = 7;
   localparam int VDIV_MSB = 9;
   localparam int MODE_FRAC_EN = 11;
   localparam int MODE_BYPASS = 7;
   localparam int SEED_LSB = 0;
   localparam int SEED_MSB = 1;
   localparam int PRESC_BIT = 19;
   localparam int STAT_PEND = 23;
   // ---------------------------------------------------------------
   // values after reset
   // ---------------------------------------------------------------
   localparam logic [DATA_W-1:0] RST_REF_DIV = 24'h00_0001;
   localparam logic [INT_W-1:0] RST_INT = 19'h0_0014;
   localparam logic [FRAC_W-1:0] RST_FRAC = 24'h00_0000;
   localparam logic [DATA_W-1:0] RST_EXACT = 24'h00_0000;
   localparam logic [2:0] RST_VDIV = 3'h0;
   localparam logic [1:0] RST_SEED = 2'h2;
   localparam logic RST_FRAC_EN = 1'b1;
   localparam logic RST_BYPASS = 1'b0;
   localparam logic RST_PRESC = 1'b0;
   // ---------------------------------------------------------------
   // accumulator start seeds
   // ---------------------------------------------------------------
   localparam logic [FRAC_W-1:0] SEED_ZERO = 24'h00_0000;
   localparam logic [FRAC_W-1:0] SEED_HALF = 24'h80_0000;
   localparam logic [FRAC_W-1:0] SEED_RAND_A = 24'hB3_8CF9;
   localparam logic [FRAC_W-1:0] SEED_RAND_B = 24'h50_F1C3;
   // settings commit state
   typedef enum logic [1:0] {
      ST_RUN = 2'b01,
      ST_PEND = 2'b10
   } fnd_state_t;
   // seed chosen by the two select bits
   function automatic logic [FRAC_W-1:0] fnd_seed(input logic [1:0] sel);
      case (sel)
         2'h0: fnd_seed = SEED_ZERO;
         2'h1: fnd_seed = SEED_HALF;
         2'h2: fnd_seed = SEED_RAND_A;
         default: fnd_seed = SEED_RAND_B;
      endcase
   endfunction
   // low word of a product, modulo the accumulator length
   function automatic logic [FRAC_W-1:0] fnd_mul_lo(
      input logic [FRAC_W-1:0] a, input logic [FRAC_W-1:0] b);
      logic [2*FRAC_W-1:0] p;
      p = a * b;
      fnd_mul_lo = p[FRAC_W-1:0];
   endfunction
endpackage

// ===== src/fnd_mod_if.sv
// signals between the settings logic and the modulator
`timescale 1ns/1ps
`default_nettype none
interface fnd_mod_if;
   import fnd_pkg::*;
   logic tick;
   logic load;
   logic frac_on;
   logic [INT_W-1:0] int_val;
   logic [FRAC_W-1:0] frac_val;
   logic [DATA_W-1:0] step_val;
   logic [FRAC_W-1:0] seed;
   logic [DIV_W-1:0] div_val;
   logic div_ok;
   modport ctrl (output tick, load, frac_on, int_val, frac_val,
      step_val, seed, input div_val, div_ok);
   modport mdl (input tick, load, frac_on, int_val, frac_val,
      step_val, seed, output div_val, div_ok);
endinterface
`default_nettype wire

// ===== src/fnd_modulator.sv
// first-order delta-sigma modulator with exact-step correction
`timescale 1ns/1ps
`default_nettype none
module fnd_modulator
   import fnd_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   fnd_mod_if.mdl m
);
   logic [FRAC_W-1:0] acc_r;
   logic [DATA_W-1:0] phase_r;
   logic [DIV_W-1:0] div_r;
   logic ok_r;
   logic exact;
   logic wrap;
   logic [FRAC_W-1:0] corr;
   logic signed [FRAC_W+1:0] sum_nxt;
   logic [1:0] carry;

   // -----------------------------------------------------------------
   // accumulation step
   // -----------------------------------------------------------------
   // once per step period the residue s*f mod 2^24 is taken out
   always_comb begin
      exact = (m.step_val != '0);
      wrap = exact && (phase_r == m.step_val - 24'h00_0001);
      corr = wrap ? fnd_mul_lo(m.step_val, m.frac_val) : '0;
      sum_nxt = $signed({2'b00, acc_r}) + $signed({2'b00, m.frac_val})
         - $signed({2'b00, corr});
      carry = sum_nxt[FRAC_W+1] ? 2'b11
         : (sum_nxt[FRAC_W] ? 2'b01 : 2'b00);
   end

   // accumulator stays 24 bits long in every mode
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         acc_r <= '0;
      end else if (m.load) begin
         acc_r <= m.seed;
      end else if (m.tick && m.frac_on) begin
         acc_r <= sum_nxt[FRAC_W-1:0];
      end
   end

   // position within the exact-step period
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         phase_r <= '0;
      end else if (m.load) begin
         phase_r <= '0;
      end else if (m.tick && m.frac_on && exact) begin
         phase_r <= wrap ? '0 : phase_r + 24'h00_0001;
      end
   end

   // divide value for the coming comparison cycle
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         div_r <= '0;
         ok_r <= 1'b0;
      end else begin
         ok_r <= m.tick;
         if (m.tick) begin
            div_r <= m.frac_on
               ? {1'b0, m.int_val} + {{(DIV_W-2){carry[1]}}, carry}
               : {1'b0, m.int_val};
         end
      end
   end

   assign m.div_val = div_r;
   assign m.div_ok = ok_r;

   // -----------------------------------------------------------------
   // checks
   // -----------------------------------------------------------------
   a_seed_reload: assert property (@(posedge clk) disable iff (!rst_n)
      m.load |=> acc_r == $past(m.seed))
      else $error("seed not reloaded");
   a_int_only: assert property (@(posedge clk) disable iff (!rst_n)
      m.tick && !m.frac_on |=> div_r == {1'b0, $past(m.int_val)})
      else $error("integer mode divide wrong");
   a_phase_bound: assert property (@(posedge clk) disable iff (!rst_n)
      exact && !m.load |-> phase_r < m.step_val)
      else $error("step phase out of range");
   c_exact_wrap: cover property (@(posedge clk) disable iff (!rst_n)
      m.tick && m.frac_on && wrap);
   c_carry_up: cover property (@(posedge clk) disable iff (!rst_n)
      m.tick && m.frac_on && carry == 2'b01);
endmodule // fnd_modulator
`default_nettype wire

// ===== src/fnd_divider_ctrl.sv
// divider control of a fractional-n synthesizer
//
// How it works
// - divide ratio is integer value plus fraction over two to the 24th
// - integer field is 19 bits, fraction 24 bits, both unsigned
// - reference input divided by ratio register gives comparison cycles
// - output divider code is written through bits 9 to 7 of 0x05
// - exact-step register holds steps per integer boundary interval
// - exact mode keeps the full 24-bit accumulator modulus
// - configured exact mode gives zero average frequency error
// - start seed reloads into the accumulator on each new setting
// - fraction runs with enable set and bypass clear, else integer
`timescale 1ns/1ps
`default_nettype none
module fnd_divider_ctrl
   import fnd_pkg::*;
(
   input wire logic clk,
   input wire logic arst_n,
   input wire logic [ADDR_W-1:0] reg_addr,
   input wire logic [DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [DATA_W-1:0] reg_rdata,
   input wire logic ref_in,
   output logic cmp_pulse,
   output logic [DIV_W-1:0] div_value,
   output logic div_valid,
   output logic [2:0] out_div_sel,
   output logic prescaler_div2,
   output logic frac_enable,
   output logic modulator_bypass,
   output logic [1:0] seed_sel
);
   // -----------------------------------------------------------------
   // declarations
   // -----------------------------------------------------------------
   logic rst_s1_r;
   logic rst_n;
   logic ref_s1_r;
   logic ref_s2_r;
   logic ref_s3_r;
   logic ref_edge;
   logic [DATA_W-1:0] ref_cnt_r;
   logic [DATA_W-1:0] ratio_m1;
   logic tick_r;
   logic [DATA_W-1:0] ref_div_r;
   logic [INT_W-1:0] sh_int_r;
   logic [FRAC_W-1:0] sh_frac_r;
   logic [DATA_W-1:0] sh_step_r;
   logic [INT_W-1:0] act_int_r;
   logic [FRAC_W-1:0] act_frac_r;
   logic [DATA_W-1:0] act_step_r;
   logic [2:0] vdiv_r;
   logic presc_r;
   logic frac_en_r;
   logic bypass_r;
   logic [1:0] seed_r;
   fnd_state_t st_r;
   logic load_r;
   logic set_wr;
   logic [DATA_W-1:0] rd_nxt;
   logic [DATA_W-1:0] rdata_r;
   fnd_mod_if m ();

   // -----------------------------------------------------------------
   // reset release
   // -----------------------------------------------------------------
   // asserted at once, released two edges later
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rst_s1_r <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_s1_r <= 1'b1;
         rst_n <= rst_s1_r;
      end
   end

   // -----------------------------------------------------------------
   // reference divider
   // -----------------------------------------------------------------
   // reference pin through two flops, third flop for the edge
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ref_s1_r <= 1'b0;
         ref_s2_r <= 1'b0;
         ref_s3_r <= 1'b0;
      end else begin
         ref_s1_r <= ref_in;
         ref_s2_r <= ref_s1_r;
         ref_s3_r <= ref_s2_r;
      end
   end

   // a ratio of zero behaves as one
   always_comb begin
      ref_edge = ref_s2_r && !ref_s3_r;
      ratio_m1 = (ref_div_r == '0) ? '0 : ref_div_r - 24'h00_0001;
   end

   // count reference edges, pulse once per ratio
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ref_cnt_r <= '0;
         tick_r <= 1'b0;
      end else begin
         tick_r <= 1'b0;
         if (ref_edge) begin
            if (ref_cnt_r >= ratio_m1) begin
               ref_cnt_r <= '0;
               tick_r <= 1'b1;
            end else begin
               ref_cnt_r <= ref_cnt_r + 24'h00_0001;
            end
         end
      end
   end

   // -----------------------------------------------------------------
   // register writes
   // -----------------------------------------------------------------
   // integer, fraction and step settings land in a shadow copy first; reference ratio acts at once
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ref_div_r <= RST_REF_DIV;
         sh_int_r <= RST_INT;
         sh_frac_r <= RST_FRAC;
         sh_step_r <= RST_EXACT;
      end else if (reg_wr) begin
         case (reg_addr)
            OFF_REF_DIV: ref_div_r <= reg_wdata;
            OFF_INT: sh_int_r <= reg_wdata[INT_W-1:0];
            OFF_FRAC: sh_frac_r <= reg_wdata[FRAC_W-1:0];
            OFF_EXACT: sh_step_r <= reg_wdata;
            default: ;
         endcase
      end
   end

   // mode, output divider and prescaler bits act at once
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         vdiv_r <= RST_VDIV;
         presc_r <= RST_PRESC;
         frac_en_r <= RST_FRAC_EN;
         bypass_r <= RST_BYPASS;
         seed_r <= RST_SEED;
      end else if (reg_wr) begin
         case (reg_addr)
            OFF_VDIV: vdiv_r <= reg_wdata[VDIV_MSB:VDIV_LSB];
            OFF_PRESC: presc_r <= reg_wdata[PRESC_BIT];
            OFF_MODE: begin
               frac_en_r <= reg_wdata[MODE_FRAC_EN];
               bypass_r <= reg_wdata[MODE_BYPASS];
               seed_r <= reg_wdata[SEED_MSB:SEED_LSB];
            end
            default: ;
         endcase
      end
   end

   // -----------------------------------------------------------------
   // settings commit
   // -----------------------------------------------------------------
   assign set_wr = reg_wr && (reg_addr == OFF_INT
      || reg_addr == OFF_FRAC || reg_addr == OFF_EXACT);

   // a write in the tick cycle keeps the commit pending
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_r <= ST_RUN;
      end else begin
         case (st_r)
            ST_RUN: if (set_wr) st_r <= ST_PEND;
            ST_PEND: if (tick_r && !set_wr) st_r <= ST_RUN;
            default: st_r <= ST_RUN;
         endcase
      end
   end

   // all three settings move to the active copy together
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         act_int_r <= RST_INT;
         act_frac_r <= RST_FRAC;
         act_step_r <= RST_EXACT;
         load_r <= 1'b0;
      end else begin
         load_r <= 1'b0;
         if (st_r == ST_PEND && tick_r) begin
            act_int_r <= sh_int_r;
            act_frac_r <= sh_frac_r;
            act_step_r <= sh_step_r;
            load_r <= 1'b1;
         end
      end
   end

   // -----------------------------------------------------------------
   // modulator
   // -----------------------------------------------------------------
   always_comb begin
      m.tick = tick_r;
      m.load = load_r;
      m.frac_on = frac_en_r && !bypass_r;
      m.int_val = act_int_r;
      m.frac_val = act_frac_r;
      m.step_val = act_step_r;
      m.seed = fnd_seed(seed_r);
   end

   fnd_modulator u_fnd_modulator (
      .clk(clk),
      .rst_n(rst_n),
      .m(m.mdl)
   );

   // -----------------------------------------------------------------
   // register reads
   // -----------------------------------------------------------------
   // unmapped offsets and reserved bits read zero
   always_comb begin
      rd_nxt = '0;
      case (reg_addr)
         OFF_REF_DIV: rd_nxt = ref_div_r;
         OFF_INT: rd_nxt[INT_W-1:0] = sh_int_r;
         OFF_FRAC: rd_nxt = sh_frac_r;
         OFF_VDIV: rd_nxt[VDIV_MSB:VDIV_LSB] = vdiv_r;
         OFF_MODE: begin
            rd_nxt[MODE_FRAC_EN] = frac_en_r;
            rd_nxt[MODE_BYPASS] = bypass_r;
            rd_nxt[SEED_MSB:SEED_LSB] = seed_r;
         end
         OFF_PRESC: rd_nxt[PRESC_BIT] = presc_r;
         OFF_EXACT: rd_nxt = sh_step_r;
         OFF_STATUS: begin
            rd_nxt[DIV_W-1:0] = m.div_val;
            rd_nxt[STAT_PEND] = (st_r == ST_PEND);
         end
         default: rd_nxt = '0;
      endcase
   end

   // read data only in the cycle after the strobe
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rdata_r <= '0;
      end else begin
         rdata_r <= reg_rd ? rd_nxt : '0;
      end
   end

   // -----------------------------------------------------------------
   // outputs
   // -----------------------------------------------------------------
   assign reg_rdata = rdata_r;
   assign cmp_pulse = tick_r;
   assign div_value = m.div_val;
   assign div_valid = m.div_ok;
   assign out_div_sel = vdiv_r;
   assign prescaler_div2 = presc_r;
   assign frac_enable = frac_en_r;
   assign modulator_bypass = bypass_r;
   assign seed_sel = seed_r;

   // -----------------------------------------------------------------
   // checks
   // -----------------------------------------------------------------
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   a_read_int: assert property (reg_rd && reg_addr == OFF_INT
      |=> reg_rdata == {5'h00, $past(sh_int_r)})
      else $error("integer readback wrong");
   a_read_idle: assert property (!reg_rd |=> reg_rdata == '0)
      else $error("read data outside read slot");
   a_ref_ratio: assert property (tick_r
      |-> $past(ref_edge) && $past(ref_cnt_r) >= $past(ratio_m1))
      else $error("comparison tick off ratio");
   a_pend_set: assert property (set_wr |=> st_r == ST_PEND)
      else $error("setting write lost");
   a_commit_all: assert property (st_r == ST_PEND && tick_r
      |=> act_int_r == $past(sh_int_r) && act_frac_r == $past(sh_frac_r)
      && act_step_r == $past(sh_step_r) && load_r)
      else $error("settings not switched together");
   a_mode_bits: assert property (reg_wr && reg_addr == OFF_MODE
      |=> frac_enable == $past(reg_wdata[MODE_FRAC_EN])
      && modulator_bypass == $past(reg_wdata[MODE_BYPASS]))
      else $error("mode bits not taken");
   a_vdiv_field: assert property (reg_wr && reg_addr == OFF_VDIV
      |=> out_div_sel == $past(reg_wdata[VDIV_MSB:VDIV_LSB]))
      else $error("output divider code wrong");
   a_div_band: assert property (tick_r && m.frac_on
      |=> div_value == {1'b0, $past(act_int_r)}
      || div_value == {1'b0, $past(act_int_r)} + 20'h0_0001
      || div_value == {1'b0, $past(act_int_r)} - 20'h0_0001)
      else $error("divide value out of band");

   c_commit: cover property (st_r == ST_PEND && tick_r);
   c_write_on_tick: cover property (set_wr && tick_r && st_r == ST_PEND);
   c_exact_on: cover property (tick_r && m.frac_on && act_step_r != '0);
endmodule // fnd_divider_ctrl
`default_nettype wire

// ===== testbench/fnd_ref_osc.sv
// reference oscillator model feeding the divider's reference pin
`timescale 1ns/1ps
`default_nettype none
module fnd_ref_osc (
   input wire logic clk,
   input wire logic run,
   input wire logic [7:0] half_cyc,
   output var logic ref_in
);
   int cnt;
   initial ref_in = 1'b0;
   // toggles every half_cyc clocks, rests low when stopped
   always @(posedge clk) begin
      if (!run) begin
         ref_in <= 1'b0;
         cnt <= 0;
      end else if (cnt + 1 >= int'(half_cyc)) begin
         ref_in <= ~ref_in; // half_cyc of 2 or more keeps edges apart
         cnt <= 0;
      end else begin
         cnt <= cnt + 1;
      end
   end
endmodule // fnd_ref_osc
`default_nettype wire

// ===== testbench/tb_fractional_n_divider_control.sv
// self-checking bench for the fractional-n divider control
`timescale 1ns/1ps
`default_nettype none
module tb_fractional_n_divider_control;
   import fnd_pkg::*;
   // ----------
   // signals
   // ----------
   logic clk = 1'b0;
   logic arst_n = 1'b0;
   logic [ADDR_W-1:0] reg_addr = '0;
   logic [DATA_W-1:0] reg_wdata = '0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [DATA_W-1:0] reg_rdata;
   logic ref_in;
   logic cmp_pulse;
   logic [DIV_W-1:0] div_value;
   logic div_valid;
   logic [2:0] out_div_sel;
   logic prescaler_div2;
   logic frac_enable;
   logic modulator_bypass;
   logic [1:0] seed_sel;
   logic osc_run = 1'b0;
   logic [7:0] osc_half = 8'h02;
   int bad_count = 0;
   int n_checks = 0;
   int cur_sel = 2;
   int g;
   logic frac_on = 1'b1;
   longint cur_int, cur_frac, cur_s, sum;
   logic [DATA_W-1:0] rv;
   logic [FRAC_W-1:0] seeds [4];
   logic [ADDR_W-1:0] ra [8] = '{OFF_REF_DIV, OFF_INT, OFF_FRAC, OFF_EXACT,
      OFF_VDIV, OFF_MODE, OFF_PRESC, 5'h1F};
   logic [DATA_W-1:0] rx [8] = '{24'h00_0001, 24'h00_0014, 24'h00_0000,
      24'h00_0000, 24'h00_0000, 24'h00_0802, 24'h00_0000, 24'h00_0000};

   // clock, 100 ns period
   always #50 clk = ~clk;

   fnd_divider_ctrl u_fnd_divider_ctrl (.clk(clk), .arst_n(arst_n),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ref_in(ref_in),
      .cmp_pulse(cmp_pulse), .div_value(div_value), .div_valid(div_valid),
      .out_div_sel(out_div_sel), .prescaler_div2(prescaler_div2),
      .frac_enable(frac_enable), .modulator_bypass(modulator_bypass),
      .seed_sel(seed_sel));
   fnd_ref_osc u_fnd_ref_osc (.clk(clk), .run(osc_run),
      .half_cyc(osc_half), .ref_in(ref_in));

   // ----------
   // tasks
   // ----------
   task automatic chk(input logic [DATA_W-1:0] got,
                      input logic [DATA_W-1:0] exp);
      n_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wrap_up();
      $display("checks=%0d mismatches=%0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [ADDR_W-1:0] a,
                     output logic [DATA_W-1:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask
   task automatic wmode(input bit en, input bit byp, input int sel);
      wr(OFF_MODE, (24'(en) << 11) | (24'(byp) << 7) | 24'(sel));
      #1 chk(24'({frac_enable, modulator_bypass, seed_sel}),
         24'({en, byp, 2'(sel)}));
      cur_sel = sel;
      frac_on = en && !byp;
   endtask
   // bounded waits for a comparison tick and for a divide value
   task automatic wait_cmp(output int c);
      c = 0;
      do begin
         @(posedge clk);
         #1 c++;
      end while (cmp_pulse !== 1'b1 && c < 400);
   endtask
   task automatic wait_div(output logic [DIV_W-1:0] v);
      int c;
      c = 0;
      do begin
         @(posedge clk);
         #1 c++;
      end while (div_valid !== 1'b1 && c < 400);
      chk({23'h0, div_valid}, 24'h00_0001);
      v = div_value;
   endtask
   // settings written with the reference stopped, then restarted
   task automatic prog(input longint ip, input longint fr, input longint s,
                       input bit all);
      osc_run <= 1'b0;
      repeat (12) @(posedge clk);
      if (all) wr(OFF_INT, DATA_W'(ip));
      wr(OFF_FRAC, DATA_W'(fr));
      if (all) wr(OFF_EXACT, DATA_W'(s));
      rd(OFF_STATUS, rv);
      chk({23'h0, rv[STAT_PEND]}, 24'h00_0001);
      cur_int = ip;
      cur_frac = fr;
      cur_s = s;
      osc_run <= 1'b1;
   endtask
   // reference accumulator, compared value by value after the commit tick
   task automatic run_model(input int n);
      longint acc, t, corr, e;
      logic [DIV_W-1:0] v;
      acc = seeds[cur_sel];
      corr = (cur_s * cur_frac) & ((1 << 24) - 1);
      sum = 0;
      wait_div(v);
      for (int j = 1; j <= n; j++) begin
         wait_div(v);
         t = acc + cur_frac;
         if (cur_s != 0 && j % cur_s == 0) t = t - corr;
         acc = t & ((1 << 24) - 1);
         e = cur_int;
         if (frac_on && t >= (1 << 24)) e = e + 1;
         if (frac_on && t < 0) e = e - 1;
         sum += v;
         chk(DATA_W'(v), DATA_W'(e));
      end
   endtask

   // ----------
   // tests
   // ----------
   initial begin
      seeds = '{SEED_ZERO, SEED_HALF, SEED_RAND_A, SEED_RAND_B};
      repeat (3) @(posedge clk);
      arst_n <= 1'b1;
      repeat (3) @(posedge clk);
      #1 chk({16'h0, frac_enable, modulator_bypass, seed_sel, out_div_sel,
         prescaler_div2}, 24'h00_00A0);
      for (int i = 0; i < 8; i++) begin
         rd(ra[i], rv);
         chk(rv, rx[i]);
      end
      // unmapped write ignored, field widths, reserved bits
      wr(5'h1F, 24'hFF_FFFF);
      rd(5'h1F, rv);
      chk(rv, 24'h00_0000);
      wr(OFF_INT, 24'hFF_FFFC); // bits above the 19-bit integer field are dropped
      rd(OFF_INT, rv);
      chk(rv, 24'h07_FFFC);
      wr(OFF_FRAC, 24'hFF_FFFF);
      rd(OFF_FRAC, rv);
      chk(rv, 24'hFF_FFFF);
      for (int c = 0; c < 8; c++) begin
         wr(OFF_VDIV, 24'hFF_FC7F | (24'(c) << 7));
         #1 chk({21'h0, out_div_sel}, 24'(c));
         rd(OFF_VDIV, rv);
         chk(rv, 24'(c) << 7);
      end
      wr(OFF_PRESC, 24'hFF_FFFF);
      #1 chk({23'h0, prescaler_div2}, 24'h00_0001);
      rd(OFF_PRESC, rv);
      chk(rv, 24'h08_0000);
      wr(OFF_PRESC, 24'h00_0000);
      #1 chk({23'h0, prescaler_div2}, 24'h00_0000);
      wr(OFF_MODE, 24'hFF_FFFF);
      rd(OFF_MODE, rv);
      chk(rv, 24'h00_0883);
      // integer, fractional and bypassed modulator
      for (int m = 0; m < 3; m++) begin
         wmode(m != 0, m != 1, 2);
         prog(24'h00_0046, 24'h19_999A, 0, 1);
         run_model(12);
      end
      rd(OFF_STATUS, rv);
      chk({23'h0, rv[STAT_PEND]}, 24'h00_0000);
      chk(24'(rv[DIV_W-1:0]), 24'h00_0046);
      // spacing of comparison ticks for several reference ratios
      osc_half <= 8'h03;
      for (int r = 0; r < 4; r++) begin
         wr(OFF_REF_DIV, 24'(r));
         wait_cmp(g);
         wait_cmp(g);
         wait_cmp(g);
         chk(24'(g), 24'((r == 0 ? 1 : r) * 6));
      end
      wr(OFF_REF_DIV, 24'h00_0001);
      osc_half <= 8'h02;
      // every start seed reloaded on a new fraction
      for (int s = 0; s < 4; s++) begin
         wmode(1, 0, s);
         prog(24'h00_0046, 24'h40_0000, 0, 1);
         run_model(8);
      end
      // exact steps of one tenth, two fractions on one step count
      wmode(1, 0, 2);
      prog(24'h00_0046, 24'h19_999A, 24'h00_000A, 1);
      run_model(30);
      chk(24'(sum), 24'h00_0837);
      prog(24'h00_0046, 24'h33_3334, 24'h00_000A, 0);
      run_model(30);
      chk(24'(sum), 24'h00_083A);
      // reset in mid-run brings the mode, output divider, prescaler and integer settings back to their reset values
      @(posedge clk);
      arst_n <= 1'b0;
      repeat (2) @(posedge clk);
      arst_n <= 1'b1;
      repeat (3) @(posedge clk);
      #1 chk({16'h0, frac_enable, modulator_bypass, seed_sel, out_div_sel,
         prescaler_div2}, 24'h00_00A0);
      rd(OFF_INT, rv);
      chk(rv, 24'h00_0014);
      wrap_up();
   end

   // cuts a hang short well after the tests should have ended
   initial begin
      repeat (40000) @(posedge clk);
      bad_count++;
      wrap_up();
   end
endmodule // tb_fractional_n_divider_control
`default_nettype wire
